// File: logic/supply_monitor_comparator_ctrl.sv
// Supply supervisor, comparator control and status register bank on APB
//
// Functional notes
// - Mains below 1 V sets power-down, interrupt
// - Line-power reads 0 below 1.0 V
// - Above 1.1 V line-power 1, power-down 0
// - Comparators stopped in level-1 reset, sleep
// - Comparator interrupt needs all three enables
// - Comparator output change sets interrupt flag
// - Bias select bit4: 20 nA or 200 nA
// - Second comparator input select bits 3:2
// - First comparator input select bits 1:0
// - Bit5 enables second comparator
// - Bit4 enables first comparator
// - Status bit6 shows second comparator output
// - Status bit5 shows first comparator output
// - Analog regulator via select or trim
// - Digital supply level bits 1:0
//
// Added by the designer: register access over APB.
`default_nettype none
`include "supply_monitor_consts.svh"

module supply_monitor_comparator_ctrl (
   // Clock, reset, enable
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic clk_en,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Analog supervisor flags, asynchronous
   input wire logic mains_below_low,
   input wire logic mains_above_high,
   // Comparator outputs, asynchronous
   input wire logic first_comparator_output,
   input wire logic second_comparator_output,
   // System state
   input wire logic sleep_active,
   // Analog controls
   output logic first_comparator_enable,
   output logic second_comparator_enable,
   output logic [1:0] first_comparator_input_sel,
   output logic [1:0] second_comparator_input_sel,
   output logic comparator_bias_select,
   output logic battery_discharge_bit,
   output logic [1:0] analog_regulator_level_sel,
   output logic [2:0] analog_regulator_trim,
   output logic analog_trim_active,
   output logic [1:0] digital_supply_level_sel,
   // Interrupts to the processor
   output logic power_down_irq,
   output logic comparator_irq,
   output logic irq
);

   // Synchronisers: stage one is read only by stage two
   logic [3:0] sync1_ff;
   logic [3:0] sync2_ff;
   wire logic [3:0] async_in = {second_comparator_output,
      first_comparator_output, mains_above_high, mains_below_low};

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         sync1_ff <= 4'h0;
         sync2_ff <= 4'h0;
      end else if (clk_en) begin
         sync1_ff <= async_in;
         sync2_ff <= sync1_ff;
      end
   end

   wire logic below_s = sync2_ff[0];
   wire logic above_s = sync2_ff[1];
   wire logic cmp_a_s = sync2_ff[2];
   wire logic cmp_b_s = sync2_ff[3];

   // Registers
   supply_monitor_pkg::reg8_t bat_ff, sel_ff, en_ff, ldo_ff, trim_ff;
   supply_monitor_pkg::reg8_t irq_en_ff, gate_ff, evt_mask_ff;
   logic power_down_ff, line_power_ff;
   logic cmp_flag_ff;
   logic [1:0] evt_ff;
   logic out_a_ff, out_b_ff;
   logic run_ff;
   logic [31:0] prdata_ff;
   logic pready_ff, pslverr_ff;
   logic pdn_irq_ff, cmp_irq_ff, irq_ff;

   // APB decode; the slave answers with no wait states
   wire logic acc = psel && penable;
   wire logic wr = acc && pwrite;
   wire logic rd = acc && !pwrite;
   wire logic aligned = paddr[1:0] == 2'h0;
   wire logic hi_zero = paddr[31:`IDX_WIDTH + 2] == '0;
   wire logic [`IDX_WIDTH-1:0] idx = paddr[`IDX_WIDTH+1:2];
   wire logic hit_bat = idx == `IDX_BAT_CTRL;
   wire logic hit_sel = idx == `IDX_CMP_SEL;
   wire logic hit_en = idx == `IDX_CMP_EN;
   wire logic hit_ldo = idx == `IDX_LDO_CTRL;
   wire logic hit_trim = idx == `IDX_LDO_TRIM;
   wire logic hit_an = idx == `IDX_AN_STATUS;
   wire logic hit_flag = idx == `IDX_IRQ_FLAG;
   wire logic hit_ien = idx == `IDX_IRQ_EN;
   wire logic hit_sys = idx == `IDX_SYS_STATE;
   wire logic hit_gate = idx == `IDX_IRQ_GATE;
   wire logic hit_evt = idx == `IDX_EVT_STATUS;
   wire logic hit_mask = idx == `IDX_EVT_MASK;
   wire logic mapped = aligned && hi_zero && (hit_bat || hit_sel
      || hit_en || hit_ldo || hit_trim || hit_an || hit_flag || hit_ien
      || hit_sys || hit_gate || hit_evt || hit_mask);
   wire logic wok = wr && mapped;
   // Reads are fetched in setup so the data stands beside pready
   wire logic setup_rd = psel && !penable && !pwrite && mapped;

   // Comparators run only outside sleep; level-1 resets clear run_ff
   wire logic nxt_run = !sleep_active;
   wire logic run_a = run_ff && en_ff[`BIT_EN_A];
   wire logic run_b = run_ff && en_ff[`BIT_EN_B];

   // Output change of a running comparator raises the flag
   wire logic chg_a = run_a && (cmp_a_s != out_a_ff);
   wire logic chg_b = run_b && (cmp_b_s != out_b_ff);
   wire logic cmp_event = chg_a || chg_b;
   wire logic nxt_out_a = run_a ? cmp_a_s : out_a_ff;
   wire logic nxt_out_b = run_b ? cmp_b_s : out_b_ff;

   // Writing one to the flag bit clears it; a new change wins
   wire logic flag_clr = wok && hit_flag && pwdata[`BIT_CMP_IRQ];
   wire logic nxt_cmp_flag = cmp_event || (cmp_flag_ff && !flag_clr);

   // Supervisor hysteresis: set below 1 V, release above 1.1 V
   wire logic pdn_rise = below_s && !power_down_ff;
   wire logic nxt_power_down = below_s ? 1'b1
      : (above_s ? 1'b0 : power_down_ff);
   wire logic nxt_line_power = below_s ? 1'b0
      : (above_s ? 1'b1 : line_power_ff);

   // Sticky event status, cleared by reading it; a new event wins
   wire logic evt_rd = setup_rd && hit_evt;
   wire logic [1:0] evt_set = {cmp_event, pdn_rise};
   wire logic [1:0] nxt_evt = evt_set | (evt_rd ? 2'h0 : evt_ff);

   // Forwarding of the comparator interrupt needs three enables
   wire logic nxt_cmp_irq = cmp_flag_ff && irq_en_ff[`BIT_CMP_IRQ]
      && gate_ff[`BIT_GATE_EXT] && gate_ff[`BIT_GATE_GLB];
   wire logic nxt_pdn_irq = power_down_ff;
   wire logic nxt_irq = |(evt_ff & evt_mask_ff[1:0]);

   wire supply_monitor_pkg::reg8_t sys_view = {6'h00,
      power_down_ff, line_power_ff};
   wire supply_monitor_pkg::reg8_t an_view = {1'b0, out_b_ff,
      out_a_ff, 5'h00};
   wire supply_monitor_pkg::reg8_t flag_view = {1'b0, cmp_flag_ff,
      6'h00};
   wire supply_monitor_pkg::reg8_t rd_mux =
      hit_bat ? bat_ff :
      hit_sel ? sel_ff :
      hit_en ? en_ff :
      hit_ldo ? ldo_ff :
      hit_trim ? trim_ff :
      hit_an ? an_view :
      hit_flag ? flag_view :
      hit_ien ? irq_en_ff :
      hit_sys ? sys_view :
      hit_gate ? gate_ff :
      hit_evt ? {6'h00, evt_ff} :
      hit_mask ? evt_mask_ff : 8'h00;
   wire logic [31:0] nxt_prdata = setup_rd ? {24'h000000, rd_mux}
      : 32'h00000000;

   // Register writes
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         bat_ff <= `RST_REG8;
         sel_ff <= `RST_REG8;
         en_ff <= `RST_REG8;
         ldo_ff <= `RST_REG8;
         trim_ff <= `RST_REG8;
         irq_en_ff <= `RST_REG8;
         gate_ff <= `RST_REG8;
         evt_mask_ff <= `RST_REG8;
      end else if (clk_en && wok) begin
         if (hit_bat) bat_ff <= {7'h00, pwdata[`BIT_BAT_DISC]};
         if (hit_sel) sel_ff <= {3'h0, pwdata[4:0]};
         if (hit_en) en_ff <= {2'h0, pwdata[5:4], 4'h0};
         if (hit_ldo) ldo_ff <= {3'h0, pwdata[4:0]};
         if (hit_trim) trim_ff <= {2'h0, pwdata[5:3], 2'h0, pwdata[0]};
         if (hit_ien) irq_en_ff <= {1'b0, pwdata[6], 6'h00};
         if (hit_gate) gate_ff <= {pwdata[7], 3'h0, pwdata[3], 3'h0};
         if (hit_mask) evt_mask_ff <= {6'h00, pwdata[1:0]};
      end
   end

   // Status, interrupts and bus answer
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         run_ff <= 1'b0;
         out_a_ff <= 1'b0;
         out_b_ff <= 1'b0;
         cmp_flag_ff <= 1'b0;
         power_down_ff <= 1'b0;
         line_power_ff <= 1'b0;
         evt_ff <= 2'h0;
         cmp_irq_ff <= 1'b0;
         pdn_irq_ff <= 1'b0;
         irq_ff <= 1'b0;
         prdata_ff <= 32'h00000000;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
      end else if (clk_en) begin
         run_ff <= nxt_run;
         out_a_ff <= nxt_out_a;
         out_b_ff <= nxt_out_b;
         cmp_flag_ff <= nxt_cmp_flag;
         power_down_ff <= nxt_power_down;
         line_power_ff <= nxt_line_power;
         evt_ff <= nxt_evt;
         cmp_irq_ff <= nxt_cmp_irq;
         pdn_irq_ff <= nxt_pdn_irq;
         irq_ff <= nxt_irq;
         prdata_ff <= nxt_prdata;
         pready_ff <= psel && !penable;
         pslverr_ff <= psel && !penable && !mapped;
      end
   end

   // Outputs straight from registers
   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign first_comparator_enable = en_ff[`BIT_EN_A];
   assign second_comparator_enable = en_ff[`BIT_EN_B];
   assign first_comparator_input_sel = sel_ff[1:0];
   assign second_comparator_input_sel = sel_ff[3:2];
   assign comparator_bias_select = sel_ff[`BIT_BIAS_SEL];
   assign battery_discharge_bit = bat_ff[`BIT_BAT_DISC];
   assign analog_regulator_level_sel = ldo_ff[4:3];
   assign analog_regulator_trim = trim_ff[5:3];
   assign analog_trim_active = trim_ff[`BIT_TRIM_EN];
   assign digital_supply_level_sel = ldo_ff[1:0];
   assign power_down_irq = pdn_irq_ff;
   assign comparator_irq = cmp_irq_ff;
   assign irq = irq_ff;

   // Checks
   a_flag_on_change: assert property (@(posedge clk_sys) disable iff
      (sys_rst) clk_en && cmp_event |=> cmp_flag_ff)
      else $error("change did not set comparator flag");
   a_flag_set_wins: assert property (@(posedge clk_sys) disable iff
      (sys_rst) clk_en && cmp_event && flag_clr |=> cmp_flag_ff)
      else $error("clear lost a comparator event");
   a_flag_sticky: assert property (@(posedge clk_sys) disable iff
      (sys_rst) clk_en && cmp_flag_ff && !flag_clr |=> cmp_flag_ff)
      else $error("comparator flag dropped without clear");
   a_irq_three_en: assert property (@(posedge clk_sys) disable iff
      (sys_rst) comparator_irq |-> $past(cmp_flag_ff)
      && $past(irq_en_ff[6]) && $past(gate_ff[3])
      && $past(gate_ff[7]))
      else $error("comparator interrupt without all enables");
   a_pdn_set: assert property (@(posedge clk_sys) disable iff
      (sys_rst) clk_en && below_s |=> power_down_ff && !line_power_ff
      ##1 power_down_irq || !clk_en)
      else $error("power-down not flagged below low threshold");
   a_line_up: assert property (@(posedge clk_sys) disable iff
      (sys_rst) clk_en && above_s && !below_s
      |=> line_power_ff && !power_down_ff)
      else $error("line power not restored above high threshold");
   a_sleep_stop: assert property (@(posedge clk_sys) disable iff
      (sys_rst) clk_en && $past(sleep_active) && $past(clk_en)
      |-> !cmp_event)
      else $error("comparator event while asleep");
   a_sync_delay: assert property (@(posedge clk_sys) disable iff
      (sys_rst) clk_en && $past(clk_en) && $past(clk_en, 2)
      |-> cmp_a_s == $past(first_comparator_output, 2))
      else $error("synchroniser depth is not two");
   a_status_track: assert property (@(posedge clk_sys) disable iff
      (sys_rst) clk_en && run_b |=> out_b_ff == $past(cmp_b_s))
      else $error("second comparator status stale");
   a_hold_disabled: assert property (@(posedge clk_sys) disable iff
      (sys_rst) clk_en && !run_a |=> out_a_ff == $past(out_a_ff))
      else $error("stopped comparator status changed");
   a_flag_clear: assert property (@(posedge clk_sys) disable iff
      (sys_rst) clk_en && flag_clr && !cmp_event |=> !cmp_flag_ff)
      else $error("comparator flag not cleared by write");
   a_flags_apart: assert property (@(posedge clk_sys) disable iff
      (sys_rst) !(power_down_ff && line_power_ff))
      else $error("power-down and line-power both set");
   a_pdn_irq_lag: assert property (@(posedge clk_sys) disable iff
      (sys_rst) clk_en |=> power_down_irq == $past(power_down_ff))
      else $error("power-down interrupt does not follow flag");
   a_evt_rd_clear: assert property (@(posedge clk_sys) disable iff
      (sys_rst) clk_en && evt_rd && !pdn_rise |=> !evt_ff[0])
      else $error("event status not cleared by read");

   // Bus answer, interrupt level and freeze checks; a lost pulse would hang the master
   a_ready_pulse: assert property (@(posedge clk_sys) disable iff
      (sys_rst) clk_en && psel && !penable |=> pready)
      else $error("no answer in first access cycle");
   a_ready_single: assert property (@(posedge clk_sys) disable iff
      (sys_rst) clk_en && pready |=> !pready)
      else $error("ready stood longer than one cycle");
   a_err_ready: assert property (@(posedge clk_sys) disable iff
      (sys_rst) pslverr |-> pready)
      else $error("error answer without ready");
   a_rdata_idle: assert property (@(posedge clk_sys) disable iff
      (sys_rst) !pready |-> prdata == 32'h00000000)
      else $error("read data outside answer cycle");
   a_rdata_upper: assert property (@(posedge clk_sys) disable iff
      (sys_rst) prdata[31:8] == 24'h000000)
      else $error("upper read data bits not zero");
   a_err_rdata: assert property (@(posedge clk_sys) disable iff
      (sys_rst) pslverr |-> prdata == 32'h00000000)
      else $error("refused read returned data");
   a_bad_write: assert property (@(posedge clk_sys) disable iff
      (sys_rst) clk_en && wr && !mapped |=> en_ff == $past(en_ff))
      else $error("refused write changed a register");
   a_irq_level: assert property (@(posedge clk_sys) disable iff
      (sys_rst) irq |-> $past(|(evt_ff & evt_mask_ff[1:0])))
      else $error("interrupt without unmasked status");
   a_freeze: assert property (@(posedge clk_sys) disable iff
      (sys_rst) !clk_en |=> $stable(cmp_flag_ff) && $stable(evt_ff))
      else $error("state moved while clock enable low");

endmodule : supply_monitor_comparator_ctrl
`default_nettype wire

// File: logic/supply_monitor_consts.svh
// Register offsets, field positions and reset values of the supply monitor
`ifndef SUPPLY_MONITOR_CONSTS_SVH
`define SUPPLY_MONITOR_CONSTS_SVH

// Register indices; the APB byte address is four times the index
`define IDX_BAT_CTRL 16'h285C
`define IDX_CMP_SEL 16'h2861
`define IDX_CMP_EN 16'h2864
`define IDX_LDO_CTRL 16'h2866
`define IDX_LDO_TRIM 16'h286A
`define IDX_AN_STATUS 16'h286B
`define IDX_IRQ_FLAG 16'h28A2
`define IDX_IRQ_EN 16'h28A5
`define IDX_SYS_STATE 16'h28C0
`define IDX_IRQ_GATE 16'h28C1
`define IDX_EVT_STATUS 16'h28C2
`define IDX_EVT_MASK 16'h28C3
`define IDX_WIDTH 16

// Field positions
`define BIT_LINE_POWER 0
`define BIT_POWER_DOWN 1
`define BIT_BAT_DISC 0
`define BIT_BIAS_SEL 4
`define BIT_SEL_B_LO 2
`define BIT_SEL_A_LO 0
`define BIT_EN_B 5
`define BIT_EN_A 4
`define BIT_OUT_B 6
`define BIT_OUT_A 5
`define BIT_CMP_IRQ 6
`define BIT_GATE_EXT 3
`define BIT_GATE_GLB 7
`define BIT_LDO_SEL_LO 3
`define BIT_LDO_DIG_LO 0
`define BIT_TRIM_LO 3
`define BIT_TRIM_EN 0
`define BIT_EVT_PDN 0
`define BIT_EVT_CMP 1

// Reset values
`define RST_REG8 8'h00

`endif

// File: logic/supply_monitor_pkg.sv
// Types shared by the supply monitor design
`default_nettype none
package supply_monitor_pkg;
   typedef logic [7:0] reg8_t;
   typedef enum logic [1:0] {
      SEL_N_VS_REF,
      SEL_P_VS_REF,
      SEL_P_VS_N_A,
      SEL_P_VS_N_B
   } input_sel_t;
endpackage : supply_monitor_pkg
`default_nettype wire

// File: tb/supply_analog_model.sv
// Behavioural model of the supervisor and the two analog comparators
`default_nettype none
module supply_analog_model (
   // Levels set by the bench
   input wire logic [15:0] mains_mv,
   input wire logic drive_a,
   input wire logic drive_b,
   // Comparator power controls
   input wire logic first_comparator_enable,
   input wire logic second_comparator_enable,
   // Supervisor and comparator outputs
   output logic mains_below_low,
   output logic mains_above_high,
   output logic first_comparator_output,
   output logic second_comparator_output
);
   timeunit 1ns;
   timeprecision 1ps;
   // Millivolt thresholds; between them both flags are low
   assign mains_below_low = mains_mv < 16'h03E8;
   assign mains_above_high = mains_mv > 16'h044C;
   // A powered-down comparator pulls its output low
   assign first_comparator_output = first_comparator_enable & drive_a;
   assign second_comparator_output = second_comparator_enable & drive_b;
endmodule : supply_analog_model
`default_nettype wire

// File: tb/supply_monitor_comparator_ctrl_test.sv
// Self-checking bench of the supply monitor register bank
`default_nettype none
`include "supply_monitor_consts.svh"
module supply_monitor_comparator_ctrl_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'h0, sys_rst = 1'h1, clk_en = 1'h1;
   logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, sleep_active = 1'h0;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, power_down_irq, comparator_irq, irq;
   logic first_comparator_enable, second_comparator_enable;
   logic comparator_bias_select, battery_discharge_bit, analog_trim_active;
   logic [1:0] first_comparator_input_sel, second_comparator_input_sel;
   logic [1:0] analog_regulator_level_sel, digital_supply_level_sel;
   logic [2:0] analog_regulator_trim;
   logic mains_below_low, mains_above_high;
   logic first_comparator_output, second_comparator_output;
   logic [15:0] mains_mv = 16'h04B0;
   logic drive_a = 1'h0, drive_b = 1'h0;
   logic [31:0] seed = 32'hB516;
   int mismatches = 0, checked = 0;
   logic [7:0] qv[$];
   logic [15:0] ri[5] = '{`IDX_CMP_SEL, `IDX_CMP_EN, `IDX_BAT_CTRL,
      `IDX_LDO_CTRL, `IDX_LDO_TRIM};
   logic [7:0] rm[5] = '{8'h1F, 8'h30, 8'h01, 8'h1B, 8'h39};

   supply_monitor_comparator_ctrl dut (.clk_sys, .sys_rst, .clk_en,
      .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .mains_below_low, .mains_above_high,
      .first_comparator_output, .second_comparator_output, .sleep_active,
      .first_comparator_enable, .second_comparator_enable,
      .first_comparator_input_sel, .second_comparator_input_sel,
      .comparator_bias_select, .battery_discharge_bit,
      .analog_regulator_level_sel, .analog_regulator_trim,
      .analog_trim_active, .digital_supply_level_sel, .power_down_irq,
      .comparator_irq, .irq);
   supply_analog_model far (.mains_mv, .drive_a, .drive_b,
      .first_comparator_enable, .second_comparator_enable,
      .mains_below_low, .mains_above_high, .first_comparator_output,
      .second_comparator_output);

   initial begin
      forever #12.5 clk_sys = ~clk_sys;
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   task automatic give_verdict(input logic timed_out);
      if (timed_out) mismatches++;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         mismatches++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk

   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : wt

   // Zero-wait slave, but the wait is still bounded, not assumed
   task automatic apb(input logic w, input logic [15:0] i,
      input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= {14'h0, i, 2'h0};
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'h1;
      for (n = 0; n < 16; n++) begin
         @(posedge clk_sys);
         if (pready === 1'h1) break;
      end
      if (n == 16) give_verdict(1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb

   task automatic rdc(input logic [15:0] i, input logic [31:0] e);
      apb(1'h0, i, 32'h0);
      chk(rd, e);
   endtask : rdc

   initial begin
      int i, r, k;
      logic [7:0] v;
      wt(6);
      sys_rst <= 1'h0;
      rdc(`IDX_CMP_SEL, 32'h0);
      rdc(`IDX_CMP_EN, 32'h0);
      rdc(`IDX_AN_STATUS, 32'h0);
      for (r = 0; r < 4; r++) begin
         for (i = 0; i < 5; i++) begin
            v = rnd() & rm[i];
            if (i == 0) v = {3'h0, v[4], 2'(r), 2'(r)};
            apb(1'h1, ri[i], {24'h0, v});
            qv.push_back(v);
            wt(1);
            case (i)
               0: chk({27'h0, comparator_bias_select, second_comparator_input_sel,
                  first_comparator_input_sel}, v);
               1: chk({26'h0, second_comparator_enable,
                  first_comparator_enable, 4'h0}, v);
               2: chk({31'h0, battery_discharge_bit}, v);
               3: chk({27'h0, analog_regulator_level_sel, 1'h0,
                  digital_supply_level_sel}, v);
               default: chk({26'h0, analog_regulator_trim, 2'h0,
                  analog_trim_active}, v);
            endcase
         end
         for (i = 0; i < 5; i++) rdc(ri[i], qv.pop_front());
      end
      apb(1'h1, `IDX_BAT_CTRL, 32'h0);
      apb(1'h1, 16'h2870, 32'hFF);
      chk(err, 1'h1);
      rdc(16'h2870, 32'h0);
      chk(err, 1'h1);
      apb(1'h1, `IDX_CMP_EN, 32'h30);
      wt(5);
      apb(1'h1, `IDX_IRQ_FLAG, 32'h40);
      drive_a <= 1'h1;
      wt(5);
      rdc(`IDX_AN_STATUS, 32'h20);
      rdc(`IDX_IRQ_FLAG, 32'h40);
      for (k = 0; k < 8; k++) begin
         apb(1'h1, `IDX_IRQ_EN, {25'h0, k[0], 6'h0});
         apb(1'h1, `IDX_IRQ_GATE, {24'h0, k[2], 3'h0, k[1], 3'h0});
         wt(2);
         chk(comparator_irq, k == 7);
      end
      apb(1'h1, `IDX_IRQ_FLAG, 32'h40);
      wt(2);
      rdc(`IDX_IRQ_FLAG, 32'h0);
      chk(comparator_irq, 1'h0);
      sleep_active <= 1'h1;
      drive_b <= 1'h1;
      wt(5);
      rdc(`IDX_AN_STATUS, 32'h20);
      sleep_active <= 1'h0;
      wt(5);
      rdc(`IDX_AN_STATUS, 32'h60);
      apb(1'h1, `IDX_EVT_MASK, 32'h1);
      apb(1'h0, `IDX_EVT_STATUS, 32'h0);
      mains_mv <= 16'h0384;
      wt(6);
      rdc(`IDX_SYS_STATE, 32'h2);
      chk({power_down_irq, irq}, 2'h3);
      rdc(`IDX_EVT_STATUS, 32'h1);
      wt(2);
      chk(irq, 1'h0);
      mains_mv <= 16'h041A;
      wt(6);
      rdc(`IDX_SYS_STATE, 32'h2);
      mains_mv <= 16'h04B0;
      wt(6);
      rdc(`IDX_SYS_STATE, 32'h1);
      chk(power_down_irq, 1'h0);
      apb(1'h1, `IDX_EVT_MASK, 32'h0);
      mains_mv <= 16'h0384;
      wt(6);
      chk(irq, 1'h0);
      rdc(`IDX_EVT_STATUS, 32'h1);
      give_verdict(1'h0);
   end
endmodule : supply_monitor_comparator_ctrl_test
`default_nettype wire
